/* File: pmx_defines.svh */
`ifndef PMX_DEFINES_SVH
`define PMX_DEFINES_SVH
// register indices, byte address is index times four
`define PMX_IDX_CTRL 7'h00
`define PMX_IDX_MODE 7'h10
`define PMX_IDX_STRAP 7'h11
`define PMX_IDX_ICSR 7'h1F
// field positions
`define PMX_CTRL_DUPLEX 8
`define PMX_CTRL_ISOLATE 10
`define PMX_ICSR_POL 9
`define PMX_ICSR_EN_LSB 12
// reset values
`define PMX_RST_POL 1'b0
`define PMX_RST_IRQ_EN 4'h0
// bus answers
`define PMX_RESP_OKAY 2'h0
`define PMX_RESP_SLVERR 2'h2
`endif

/* File: pmx_pkg.sv */
package pmx_pkg;
   // interface mode of the mac-side pins
   typedef enum logic [1:0] {
      PMX_MII = 2'h0,
      PMX_RMII = 2'h1,
      PMX_SMII = 2'h2,
      PMX_B2B = 2'h3
   } pmx_mode_e;
   // power-up sequence, one-hot
   typedef enum logic [3:0] {
      PMX_WAIT = 4'h1,
      PMX_SAMPLE = 4'h2,
      PMX_LOAD = 4'h4,
      PMX_RUN = 4'h8
   } pmx_seq_e;
   // the five shared strap/output pins
   typedef struct packed {
      logic rxd0;
      logic rxdv;
      logic rxer;
      logic col;
      logic crs;
   } pmx_pins_s;
   // receive side values from the phy core
   typedef struct packed {
      logic rxd0;
      logic smii_rx;
      logic rxdv;
      logic crs_dv;
      logic rxer;
      logic col;
      logic crs;
      logic txc;
   } pmx_core_rx_s;
   // latched straps
   typedef struct packed {
      logic valid;
      logic duplex;
      logic isolate;
      logic cfg_strap_two;
      logic cfg_strap_one;
      logic cfg_strap_zero;
   } pmx_straps_s;
endpackage : pmx_pkg

/* File: pmx_strap.sv */
`timescale 1ns/100ps
`default_nettype none
module pmx_strap (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // sample strobe and pin levels
   input wire logic sample,
   input wire pmx_pkg::pmx_pins_s pins_in,
   // latched values
   output pmx_pkg::pmx_straps_s straps
);
   pmx_pkg::pmx_straps_s st, next_st;

   // take the pull levels once, on the sample strobe
   always_comb begin
      next_st = st;
      if (sample && !st.valid) begin
         next_st.valid = 1'b1;
         next_st.duplex = pins_in.rxd0;
         next_st.isolate = pins_in.rxer;
         next_st.cfg_strap_two = pins_in.rxdv;
         next_st.cfg_strap_one = pins_in.crs;
         next_st.cfg_strap_zero = pins_in.col;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign straps = st;

   // once valid, straps never move
   strap_hold_a: assert property (@(posedge core_clk)
      disable iff (!resetn) st.valid |=> $stable(st))
      else $error("strap value changed after sampling");
endmodule : pmx_strap
`default_nettype wire

/* File: pmx_top.sv */
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pmx_defines.svh"
module pmx_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // axi4-lite slave
   input wire logic [8:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [8:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // shared strap/output pins
   input wire pmx_pkg::pmx_pins_s pin_in,
   output pmx_pkg::pmx_pins_s pin_out,
   output pmx_pkg::pmx_pins_s pin_oe,
   // transmit clock pin
   input wire logic txc_in,
   output logic txc_out,
   output logic txc_oe,
   // transmit data pins txd0, txd1
   input wire logic txd0_in,
   input wire logic txd1_in,
   // phy core side
   input wire pmx_pkg::pmx_core_rx_s core_rx,
   input wire logic [3:0] irq_event,
   output logic core_txc_ext,
   output logic core_smii_tx,
   output logic core_smii_sync,
   output logic duplex,
   output logic isolate,
   // interrupt pin
   output logic irq_out
);
   typedef struct packed {
      pmx_pkg::pmx_seq_e seq;
      logic aw_got;
      logic w_got;
      logic [6:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic duplex;
      logic isolate;
      pmx_pkg::pmx_mode_e mode;
      logic irq_pol;
      logic [3:0] irq_en;
      logic [3:0] irq_sts;
      logic irq_out;
      pmx_pkg::pmx_pins_s pin_out;
      pmx_pkg::pmx_pins_s pin_oe;
      logic txc_out;
      logic txc_oe;
      logic core_txc_ext;
      logic core_smii_tx;
      logic core_smii_sync;
   } pmx_state_s;

   pmx_state_s st, next_st;
   pmx_pkg::pmx_straps_s straps;
   logic [6:0] ridx;
   logic rd_take;
   logic [3:0] sts_set;
   logic drive;

   // strap latch, strobed in the sample state
   pmx_strap u_strap (
      .core_clk(core_clk),
      .resetn(resetn),
      .sample(st.seq == pmx_pkg::PMX_SAMPLE),
      .pins_in(pin_in),
      .straps(straps)
   );

   // next state of sequence, bus slave, registers and pins
   always_comb begin
      next_st = st;
      ridx = s_axi_araddr[8:2];
      rd_take = s_axi_arvalid && st.arready;
      drive = (st.seq == pmx_pkg::PMX_RUN) && !st.isolate;
      sts_set = irq_event;
      case (st.seq)
         pmx_pkg::PMX_WAIT: next_st.seq = pmx_pkg::PMX_SAMPLE;
         pmx_pkg::PMX_SAMPLE: next_st.seq = pmx_pkg::PMX_LOAD;
         pmx_pkg::PMX_LOAD: begin
            next_st.seq = pmx_pkg::PMX_RUN;
            next_st.duplex = straps.duplex;
            next_st.isolate = straps.isolate;
         end
         pmx_pkg::PMX_RUN: next_st.seq = pmx_pkg::PMX_RUN;
         default: next_st.seq = pmx_pkg::PMX_WAIT;
      endcase
      // write address and data captured in either order
      if (s_axi_awvalid && st.awready) begin
         next_st.aw_got = 1'b1;
         next_st.waddr = s_axi_awaddr[8:2];
      end
      if (s_axi_wvalid && st.wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      // perform the write once both halves are held
      if (st.aw_got && st.w_got && !st.bvalid) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = `PMX_RESP_OKAY;
         case (st.waddr)
            `PMX_IDX_CTRL: begin
               if (st.wstrb[1]) begin
                  next_st.duplex = st.wdata[`PMX_CTRL_DUPLEX];
                  next_st.isolate = st.wdata[`PMX_CTRL_ISOLATE];
               end
            end
            `PMX_IDX_MODE: begin
               if (st.wstrb[0]) begin
                  next_st.mode = pmx_pkg::pmx_mode_e'(st.wdata[1:0]);
               end
            end
            `PMX_IDX_ICSR: begin
               if (st.wstrb[1]) begin
                  next_st.irq_pol = st.wdata[`PMX_ICSR_POL];
                  next_st.irq_en = st.wdata[`PMX_ICSR_EN_LSB +: 4];
               end
            end
            `PMX_IDX_STRAP: next_st.bresp = `PMX_RESP_OKAY;
            default: next_st.bresp = `PMX_RESP_SLVERR;
         endcase
      end
      next_st.awready = !next_st.aw_got && !next_st.bvalid;
      next_st.wready = !next_st.w_got && !next_st.bvalid;
      // read path, one outstanding read
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (rd_take) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = `PMX_RESP_OKAY;
         next_st.rdata = 32'h0;
         case (ridx)
            `PMX_IDX_CTRL: begin
               next_st.rdata[`PMX_CTRL_DUPLEX] = st.duplex;
               next_st.rdata[`PMX_CTRL_ISOLATE] = st.isolate;
            end
            `PMX_IDX_MODE: next_st.rdata[1:0] = st.mode;
            `PMX_IDX_STRAP: next_st.rdata[5:0] = straps;
            `PMX_IDX_ICSR: begin
               // status read clears, new events win
               next_st.rdata[3:0] = st.irq_sts;
               next_st.rdata[`PMX_ICSR_POL] = st.irq_pol;
               next_st.rdata[`PMX_ICSR_EN_LSB +: 4] = st.irq_en;
               next_st.irq_sts = 4'h0;
            end
            default: next_st.rresp = `PMX_RESP_SLVERR;
         endcase
      end
      next_st.irq_sts = next_st.irq_sts | sts_set;
      next_st.arready = !next_st.rvalid;
      next_st.irq_out = st.irq_pol ~^ (|(st.irq_sts & st.irq_en));
      // pins stay undriven until straps are in
      next_st.pin_oe = drive ? 5'h1F : 5'h00;
      next_st.txc_oe = drive && (st.mode != pmx_pkg::PMX_B2B);
      next_st.txc_out = core_rx.txc;
      next_st.core_txc_ext = txc_in;
      // smii serial transmit and sync from the mac
      next_st.core_smii_tx = txd0_in;
      next_st.core_smii_sync = txd1_in;
      // smii serial receive on the rxd0 pin
      next_st.pin_out.rxd0 = (st.mode == pmx_pkg::PMX_SMII) ?
         core_rx.smii_rx : core_rx.rxd0;
      // rmii combined carrier-sense and data valid
      next_st.pin_out.rxdv = (st.mode == pmx_pkg::PMX_RMII) ?
         core_rx.crs_dv : core_rx.rxdv;
      next_st.pin_out.rxer = core_rx.rxer;
      next_st.pin_out.col = core_rx.col;
      next_st.pin_out.crs = core_rx.crs;
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st <= '0;
         st.seq <= pmx_pkg::PMX_WAIT;
         st.mode <= pmx_pkg::PMX_MII;
         st.irq_pol <= `PMX_RST_POL;
         st.irq_en <= `PMX_RST_IRQ_EN;
         st.irq_out <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rresp = st.rresp;
   assign s_axi_rdata = st.rdata;
   assign pin_out = st.pin_out;
   assign pin_oe = st.pin_oe;
   assign txc_out = st.txc_out;
   assign txc_oe = st.txc_oe;
   assign core_txc_ext = st.core_txc_ext;
   assign core_smii_tx = st.core_smii_tx;
   assign core_smii_sync = st.core_smii_sync;
   assign duplex = st.duplex;
   assign isolate = st.isolate;
   assign irq_out = st.irq_out;

   // checks
   duplex_load_a: assert property (@(posedge core_clk)
      disable iff (!resetn) st.seq == pmx_pkg::PMX_SAMPLE |=> ##1 st.duplex
      == $past(pin_in.rxd0, 2)) else $error("duplex not loaded from strap");
   cfg_straps_a: assert property (@(posedge core_clk)
      disable iff (!resetn) st.seq == pmx_pkg::PMX_SAMPLE |=>
      {straps.cfg_strap_two, straps.cfg_strap_one, straps.cfg_strap_zero} ==
      $past({pin_in.rxdv, pin_in.crs, pin_in.col}))
      else $error("config straps wrong");
   iso_float_a: assert property (@(posedge core_clk)
      disable iff (!resetn) st.isolate && $past(st.isolate) |-> !txc_oe &&
      st.pin_oe == 5'h00) else $error("pins driven while isolated");
   irq_pol_a: assert property (@(posedge core_clk)
      disable iff (!resetn) $past(resetn) |-> irq_out == ($past(st.irq_pol)
      ~^ (|($past(st.irq_sts) & $past(st.irq_en)))))
      else $error("interrupt pin polarity wrong");
   txc_dir_a: assert property (@(posedge core_clk)
      disable iff (!resetn) st.mode == pmx_pkg::PMX_B2B |=> !txc_oe)
      else $error("transmit clock driven in back-to-back");
   rmii_crsdv_a: assert property (@(posedge core_clk)
      disable iff (!resetn) st.mode == pmx_pkg::PMX_RMII |=> pin_out.rxdv ==
      $past(core_rx.crs_dv)) else $error("rmii valid pin wrong");
   smii_rx_a: assert property (@(posedge core_clk)
      disable iff (!resetn) st.mode == pmx_pkg::PMX_SMII |=> pin_out.rxd0 ==
      $past(core_rx.smii_rx)) else $error("smii receive pin wrong");
   smii_tx_a: assert property (@(posedge core_clk)
      disable iff (!resetn) 1'b1 |=> core_smii_sync == $past(txd1_in) &&
      core_smii_tx == $past(txd0_in)) else $error("smii transmit path wrong");
   irq_sticky_a: assert property (@(posedge core_clk)
      disable iff (!resetn) irq_event[0] |=> st.irq_sts[0])
      else $error("interrupt event lost");
   no_drive_a: assert property (@(posedge core_clk)
      disable iff (!resetn) st.seq != pmx_pkg::PMX_RUN |=> st.pin_oe == 5'h00)
      else $error("pins driven before strap sampling");
   run_cov: cover property (@(posedge core_clk) st.seq == pmx_pkg::PMX_RUN);
   irq_cov: cover property (@(posedge core_clk) st.irq_pol && irq_out);
   smii_cov: cover property (@(posedge core_clk)
      st.mode == pmx_pkg::PMX_SMII && drive);
   b2b_cov: cover property (@(posedge core_clk)
      st.mode == pmx_pkg::PMX_B2B && s_axi_bvalid);
endmodule : pmx_top
`default_nettype wire

/* File: pmx_mac_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pmx_mac_model (
   // clock
   input wire logic core_clk,
   // board pull levels and phy pin drive
   input wire pmx_pkg::pmx_pins_s pull,
   input wire pmx_pkg::pmx_pins_s pin_out,
   input wire pmx_pkg::pmx_pins_s pin_oe,
   input wire logic txc_out,
   input wire logic txc_oe,
   // resolved pin levels and mac drive
   output var pmx_pkg::pmx_pins_s pin_in,
   output logic txc_in,
   output logic txd0,
   output logic txd1
);
   logic [3:0] bit_cnt = 4'h0;
   logic [7:0] pat = 8'hA5;
   logic mac_txc = 1'b0;
   // serial pattern, ten-bit sync frame and back-to-back clock
   always @(posedge core_clk) begin
      bit_cnt <= (bit_cnt == 4'h9) ? 4'h0 : bit_cnt + 4'h1;
      pat <= {pat[6:0], pat[7] ^ pat[5]};
      mac_txc <= ~mac_txc;
   end
   assign txd0 = pat[0];
   assign txd1 = (bit_cnt == 4'h0);
   // mac clocks txc when phy releases it
   assign txc_in = txc_oe ? txc_out : mac_txc;
   // undriven pins show the pull level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & pull);
endmodule : pmx_mac_model
`default_nettype wire

/* File: pmx_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pmx_defines.svh"
module pmx_top_test;
   // bench signals
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [8:0] aw = 9'h000;
   logic [8:0] ar = 9'h000;
   logic [31:0] wd = 32'h0;
   logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic awr, wrdy, bv, arr, rv, txc_in, txc_out, txc_oe, txd0, txd1;
   logic txc_ext, smii_tx, smii_sync, duplex, isolate, irq_out;
   logic [1:0] br, rr;
   logic [31:0] rd;
   pmx_pkg::pmx_pins_s pull = 5'h00;
   pmx_pkg::pmx_pins_s pin_in, pin_out, pin_oe;
   pmx_pkg::pmx_core_rx_s core_rx = 8'h51;
   logic [3:0] irq_event = 4'h0;
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   // design and mac partner
   pmx_top i_dut (.core_clk(core_clk), .resetn(resetn),
      .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(brdy), .s_axi_araddr(ar), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rrdy), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .txc_in(txc_in),
      .txc_out(txc_out), .txc_oe(txc_oe), .txd0_in(txd0),
      .txd1_in(txd1), .core_rx(core_rx), .irq_event(irq_event),
      .core_txc_ext(txc_ext), .core_smii_tx(smii_tx),
      .core_smii_sync(smii_sync), .duplex(duplex), .isolate(isolate),
      .irq_out(irq_out));
   pmx_mac_model i_mac (.core_clk(core_clk), .pull(pull),
      .pin_out(pin_out), .pin_oe(pin_oe), .txc_out(txc_out),
      .txc_oe(txc_oe), .pin_in(pin_in), .txc_in(txc_in), .txd0(txd0),
      .txd1(txd1));
   // clock
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   // hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches = mismatches + 1;
         conclude();
      end
   end
   task conclude;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task cwait(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cwait
   task axi_wr(input logic [8:0] a, input logic [31:0] d,
               output logic [1:0] r);
      @(posedge core_clk);
      aw <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
         if (bv === 1'b1) break;
      end
      r = br;
      brdy <= 1'b0;
   endtask : axi_wr
   task axi_rd(input logic [8:0] a, output logic [31:0] d,
               output logic [1:0] r);
      @(posedge core_clk);
      ar <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (arv && arr) arv <= 1'b0;
         if (rv === 1'b1) break;
      end
      d = rd;
      r = rr;
      rrdy <= 1'b0;
   endtask : axi_rd
   task t_strap(input pmx_pkg::pmx_pins_s p);
      logic [31:0] d;
      logic [1:0] r;
      @(posedge core_clk);
      resetn <= 1'b0;
      pull <= p;
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) begin
         cwait(1);
         chk("pin_oe sampling", 32'h0, pin_oe);
      end
      cwait(4);
      chk("duplex", p.rxd0, duplex);
      chk("isolate", p.rxer, isolate);
      chk("pin_oe run", p.rxer ? 32'h0 : 32'h1F, pin_oe);
      chk("txc_oe", !p.rxer, txc_oe);
      axi_rd({`PMX_IDX_STRAP, 2'h0}, d, r);
      chk("strap", {1'b1, p.rxd0, p.rxer, p.rxdv, p.crs, p.col}, d);
      $display("test strap done");
   endtask : t_strap
   task t_bus;
      logic [31:0] d;
      logic [1:0] r;
      axi_rd({`PMX_IDX_CTRL, 2'h0}, d, r);
      chk("ctrl duplex", 32'h1, d[8]);
      axi_wr({`PMX_IDX_CTRL, 2'h0}, 32'h0, r);
      cwait(2);
      chk("duplex cleared", 32'h0, duplex);
      // isolate through the control register floats the pins
      axi_wr({`PMX_IDX_CTRL, 2'h0}, 32'h400, r);
      cwait(3);
      chk("isolate ctrl", 32'h1, isolate);
      chk("pins floated", 32'h0, pin_oe);
      chk("txc floated", 32'h0, txc_oe);
      axi_rd({`PMX_IDX_CTRL, 2'h0}, d, r);
      chk("ctrl isolate", 32'h400, d);
      axi_wr({`PMX_IDX_CTRL, 2'h0}, 32'h0, r);
      cwait(3);
      chk("pins back", 32'h1F, pin_oe);
      axi_rd({7'h05, 2'h0}, d, r);
      chk("unmapped rresp", `PMX_RESP_SLVERR, r);
      chk("unmapped rdata", 32'h0, d);
      axi_wr({7'h05, 2'h0}, 32'hFFFFFFFF, r);
      chk("unmapped bresp", `PMX_RESP_SLVERR, r);
      axi_rd({`PMX_IDX_MODE, 2'h0}, d, r);
      chk("mode reset", 32'h0, d);
      $display("test bus done");
   endtask : t_bus
   task t_mode;
      logic [1:0] r;
      logic a, b, c;
      for (int m = 0; m < 4; m++) begin
         axi_wr({`PMX_IDX_MODE, 2'h0}, 32'(m), r);
         cwait(3);
         chk("txc_oe", m != 3, txc_oe);
         chk("rxdv pin", m == 1, pin_out.rxdv);
         chk("rxd0 pin", m == 2, pin_out.rxd0);
         if (m == 0) chk("txc_out", 32'h1, txc_out);
         repeat (10) begin
            a = txd0;
            b = txd1;
            c = txc_in;
            cwait(1);
            if (m == 2) chk("smii tx", a, smii_tx);
            if (m == 2) chk("smii sync", b, smii_sync);
            if (m == 3) chk("txc ext", c, txc_ext);
         end
         // every core receive bit flipped, the bits the mode selects show through on the pins
         @(posedge core_clk);
         core_rx <= 8'hAE;
         cwait(2);
         chk("pins flipped", {27'h0, m != 2, m != 1, 3'h7}, pin_out);
         chk("txc_out low", 32'h0, txc_out);
         @(posedge core_clk);
         core_rx <= 8'h51;
      end
      axi_wr({`PMX_IDX_MODE, 2'h0}, 32'h0, r);
      $display("test mode done");
   endtask : t_mode
   task pulse(input logic [3:0] e);
      @(posedge core_clk);
      irq_event <= e;
      @(posedge core_clk);
      irq_event <= 4'h0;
      cwait(3);
   endtask : pulse
   task t_irq;
      logic [31:0] d;
      logic [1:0] r;
      axi_wr({`PMX_IDX_ICSR, 2'h0}, 32'h1000, r);
      cwait(3);
      chk("irq idle low pol", 32'h1, irq_out);
      pulse(4'h4);
      chk("irq masked", 32'h1, irq_out);
      pulse(4'h1);
      chk("irq active low", 32'h0, irq_out);
      axi_rd({`PMX_IDX_ICSR, 2'h0}, d, r);
      chk("icsr status", 32'h1, d[0]);
      chk("icsr enable", 32'h1, d[15:12]);
      cwait(3);
      chk("irq cleared", 32'h1, irq_out);
      axi_wr({`PMX_IDX_ICSR, 2'h0}, 32'h1200, r);
      cwait(3);
      chk("irq idle high pol", 32'h0, irq_out);
      pulse(4'h1);
      chk("irq active high", 32'h1, irq_out);
      axi_rd({`PMX_IDX_ICSR, 2'h0}, d, r);
      chk("icsr pol", 32'h1, d[9]);
      // upper event line with its own enable, active low again
      axi_wr({`PMX_IDX_ICSR, 2'h0}, 32'hA000, r);
      pulse(4'h8);
      chk("irq event three", 32'h0, irq_out);
      axi_rd({`PMX_IDX_ICSR, 2'h0}, d, r);
      chk("icsr status three", 32'h8, d[3:0]);
      chk("icsr enable three", 32'hA, d[15:12]);
      $display("test irq done");
   endtask : t_irq
   // main sequence
   initial begin
      t_strap(5'b00101);
      t_strap(5'b11010);
      t_bus();
      t_mode();
      t_irq();
      conclude();
   end
endmodule : pmx_top_test
`default_nettype wire
